/* pkg/swbw_pkg.sv */
// shared constants and types of the single-wire write master
package swbw_pkg;
   localparam int CLK_NS      = 40;
   localparam int BUF_DEPTH   = 16;
   localparam int RST_LOW_NS  = 480000;
   localparam int RST_REC_NS  = 480000;
   localparam int PRES_SMP_NS = 70000;
   localparam int SLOT_NS     = 70000;
   localparam int WR0_LOW_NS  = 60000;
   localparam int WR1_LOW_NS  = 6000;
   localparam int RD_LOW_NS   = 6000;
   localparam int RD_SMP_NS   = 12000;
   localparam int RD_MAX_NS   = 15000;

   // least times round up, longest times round down, never below one cycle
   function automatic int swbw_cyc_up(input int ns);
      swbw_cyc_up = ((ns + CLK_NS - 1) / CLK_NS < 1) ? 1 : (ns + CLK_NS - 1) / CLK_NS;
   endfunction : swbw_cyc_up
   function automatic int swbw_cyc_dn(input int ns);
      swbw_cyc_dn = (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
   endfunction : swbw_cyc_dn

   localparam int RST_LOW_CYC  = swbw_cyc_up(RST_LOW_NS);
   localparam int RST_REC_CYC  = swbw_cyc_up(RST_REC_NS);
   localparam int PRES_SMP_CYC = swbw_cyc_up(PRES_SMP_NS);
   localparam int SLOT_CYC     = swbw_cyc_up(SLOT_NS);
   localparam int WR0_LOW_CYC  = swbw_cyc_up(WR0_LOW_NS);
   localparam int WR1_LOW_CYC  = swbw_cyc_up(WR1_LOW_NS);
   localparam int RD_LOW_CYC   = swbw_cyc_up(RD_LOW_NS);
   localparam int RD_SMP_CYC   = swbw_cyc_dn(RD_SMP_NS);
   localparam int RD_MAX_CYC   = swbw_cyc_dn(RD_MAX_NS);

   localparam logic [2:0] MODE_RST_PRE  = 3'h1;
   localparam logic [2:0] MODE_RST_POST = 3'h2;
   localparam logic [2:0] MODE_BIT      = 3'h4;

   typedef enum logic [1:0] {K_RESET, K_WR0, K_WR1, K_READ} swbw_kind_t;
   typedef enum logic [2:0] {S_IDLE, S_RST_PRE, S_DATA, S_RST_POST, S_READ} swbw_state_t;
endpackage : swbw_pkg

/* pkg/swbw_slot_if.sv */
// link between the sequencer and the slot timer
`timescale 1ns/100ps
interface swbw_slot_if;
   import swbw_pkg::*;
   logic       start;
   swbw_kind_t kind;
   logic       line_in;
   logic       done;
   logic       bit_val;
   logic       oe;
   modport seq  (output start, kind, line_in, input done, bit_val, oe);
   modport slot (input start, kind, line_in, output done, bit_val, oe);
endinterface : swbw_slot_if

/* core/swbw_slot.sv */
// one timed slot on the line: reset with presence sample, write 0/1, or read
`timescale 1ns/100ps
module swbw_slot
   import swbw_pkg::*;
#(
   parameter int RST_LOW = RST_LOW_CYC,
   parameter int RST_REC = RST_REC_CYC
) (
   input wire logic     clk,
   input wire logic     rst_n,
   swbw_slot_if.slot    sif
);
   localparam logic [15:0] RST_LOW_L = 16'(RST_LOW);
   localparam logic [15:0] RST_END_L = 16'(RST_LOW + RST_REC);
   localparam logic [15:0] RST_SMP_L = 16'(RST_LOW + PRES_SMP_CYC);
   localparam logic [15:0] SLOT_L    = 16'(SLOT_CYC);

   logic       active;
   logic [15:0] cnt;
   swbw_kind_t kind_q;
   logic [15:0] low_len;
   logic [15:0] end_cnt;
   logic [15:0] smp_cnt;

   always_comb begin
      case (kind_q)
         K_RESET: begin
            low_len = RST_LOW_L;
            end_cnt = RST_END_L;
            smp_cnt = RST_SMP_L;
         end
         K_WR0: begin
            low_len = 16'(WR0_LOW_CYC);
            end_cnt = SLOT_L;
            smp_cnt = SLOT_L;
         end
         K_WR1: begin
            low_len = 16'(WR1_LOW_CYC);
            end_cnt = SLOT_L;
            smp_cnt = SLOT_L;
         end
         default: begin
            low_len = 16'(RD_LOW_CYC);
            end_cnt = SLOT_L;
            smp_cnt = 16'(RD_SMP_CYC);
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         active <= 1'b0;
         cnt    <= 16'h0000;
         kind_q <= K_RESET;
      end else if (!active) begin
         if (sif.start) begin
            active <= 1'b1;
            kind_q <= sif.kind;
            cnt    <= 16'h0000;
         end
      end else begin
         cnt <= cnt + 16'h0001;
         if (cnt == end_cnt - 16'h0001) begin
            active <= 1'b0;
         end
      end
   end

   // pull low for the slot's low phase, then let the pull-up take the line
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sif.oe <= 1'b0;
      end else if (!active && sif.start) begin
         sif.oe <= 1'b1;
      end else if (active && cnt == low_len - 16'h0001) begin
         sif.oe <= 1'b0;
      end
   end

   // reset slot: bit_val means a slave pulled low; read slot: the line level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sif.bit_val <= 1'b0;
         sif.done    <= 1'b0;
      end else begin
         sif.done <= active && cnt == end_cnt - 16'h0001;
         if (active && cnt == smp_cnt) begin
            sif.bit_val <= (kind_q == K_RESET) ? !sif.line_in : sif.line_in;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   read_sample_time_a: assert property (
      active && kind_q == K_READ && cnt == 16'h0000 |-> ##[1:374] (cnt == smp_cnt))
      else $error("read slot sampled too late");
   low_phase_len_a: assert property (
      $rose(sif.oe) && kind_q == K_WR1 |-> sif.oe [*8])
      else $error("write-one low phase too short");
endmodule : swbw_slot

/* core/swbw_master.sv */
// single-wire bus write master: mode sequencing, buffer and presence check
// Function
// - accept a 3-bit mode 0..7 selecting reset placement and byte or bit transfer
// - modes 0..3 move bytes; no reset, reset before, after, or both
// - modes 4..7 use the same reset placement but move one bit per item
// - in bit mode only bit 0 of each buffer item is sent
// - a reset before data without presence abandons the transfer; a missing presence at either reset flags the absent slave
// - reset-before-data drives reset, samples presence, then sends data
// - line driver toggles per slot and is released when the operation ends
// - with a count send that many leading bytes in order, clipped to the buffer depth, else the whole buffer
// - every byte goes onto the line least significant bit first
// - a read slot is a brief low pulse sampled within 15 us of its fall
`timescale 1ns/100ps
module swbw_master
   import swbw_pkg::*;
#(
   parameter int RST_LOW = RST_LOW_CYC,
   parameter int RST_REC = RST_REC_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        start,
   input  wire logic [2:0]  mode,
   input  wire logic        use_count,
   input  wire logic [4:0]  count,
   input  wire logic        rd_start,
   input  wire logic        buf_we,
   input  wire logic [3:0]  buf_addr,
   input  wire logic [7:0]  buf_wdata,
   input  wire logic        line_i,
   output logic             line_o,
   output logic             line_oe,
   output logic             busy,
   output logic             done,
   output logic             absent_slave,
   output logic             rd_bit,
   output logic             rd_valid
);
   swbw_slot_if sif ();

   swbw_slot #(.RST_LOW(RST_LOW), .RST_REC(RST_REC)) u_slot (
      .clk   (clk),
      .rst_n (rst_n),
      .sif   (sif)
   );

   logic [7:0]  mem [BUF_DEPTH];
   logic        line_s1;
   logic        line_s2;
   swbw_state_t state;
   swbw_state_t next_state;
   logic [2:0]  mode_q;
   logic [4:0]  n_items;
   logic [4:0]  n_load;
   logic [4:0]  idx;
   logic [2:0]  bitn;
   logic        wait_q;
   logic        slot_ok;
   logic        last_bit;
   logic        last_item;

   function automatic swbw_state_t data_or_post(input logic [4:0] n, input logic [2:0] m);
      if (n != 5'h00) begin
         data_or_post = S_DATA;
      end else if ((m & MODE_RST_POST) != 3'h0) begin
         data_or_post = S_RST_POST;
      end else begin
         data_or_post = S_IDLE;
      end
   endfunction : data_or_post

   // pin passes two flops before the slot timer samples it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_s1 <= 1'b1;
         line_s2 <= 1'b1;
      end else begin
         line_s1 <= line_i;
         line_s2 <= line_s1;
      end
   end
   assign sif.line_in = line_s2;
   assign line_oe     = sif.oe;

   // output level is a constant low; only the enable ever moves
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_o <= 1'b0;
      end else begin
         line_o <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (buf_we) begin
         mem[buf_addr] <= buf_wdata;
      end
   end

   // count above the buffer depth is clipped; no count means the whole buffer
   assign n_load    = !use_count ? 5'(BUF_DEPTH) : (count > 5'(BUF_DEPTH) ? 5'(BUF_DEPTH) : count);
   assign slot_ok   = wait_q && sif.done;
   assign last_bit  = ((mode_q & MODE_BIT) != 3'h0) || bitn == 3'h7;
   assign last_item = idx + 5'h01 == n_items;

   always_comb begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (start) begin
               next_state = ((mode & MODE_RST_PRE) != 3'h0) ? S_RST_PRE : data_or_post(n_load, mode);
            end else if (rd_start) begin
               next_state = S_READ;
            end
         end
         S_RST_PRE: begin
            if (slot_ok) begin
               next_state = !sif.bit_val ? S_IDLE : data_or_post(n_items, mode_q);
            end
         end
         S_DATA: begin
            if (slot_ok && last_bit && last_item) begin
               next_state = ((mode_q & MODE_RST_POST) != 3'h0) ? S_RST_POST : S_IDLE;
            end
         end
         S_RST_POST: begin
            if (slot_ok) begin
               next_state = S_IDLE;
            end
         end
         S_READ: begin
            if (slot_ok) begin
               next_state = S_IDLE;
            end
         end
         default: next_state = S_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= S_IDLE;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else begin
         state <= next_state;
         busy  <= next_state != S_IDLE;
         done  <= state != S_IDLE && state != S_READ && next_state == S_IDLE;
      end
   end

   // item and bit walk: index order, least significant bit first
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q  <= 3'h0;
         n_items <= 5'h00;
         idx     <= 5'h00;
         bitn    <= 3'h0;
      end else if (state == S_IDLE && start) begin
         mode_q  <= mode;
         n_items <= n_load;
         idx     <= 5'h00;
         bitn    <= 3'h0;
      end else if (state == S_DATA && slot_ok) begin
         if (last_bit) begin
            bitn <= 3'h0;
            idx  <= idx + 5'h01;
         end else begin
            bitn <= bitn + 3'h1;
         end
      end
   end

   // one slot at a time; the next start is raised two cycles after the previous slot's done
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_q   <= 1'b0;
         sif.start <= 1'b0;
         sif.kind  <= K_RESET;
      end else begin
         sif.start <= 1'b0;
         if (slot_ok) begin
            wait_q <= 1'b0;
         end else if (!wait_q && state != S_IDLE) begin
            wait_q    <= 1'b1;
            sif.start <= 1'b1;
            case (state)
               S_DATA:  sif.kind <= mem[idx[3:0]][bitn] ? K_WR1 : K_WR0;
               S_READ:  sif.kind <= K_READ;
               default: sif.kind <= K_RESET;
            endcase
         end
      end
   end

   // absent flag stands until the next accepted write; a read leaves it alone
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         absent_slave <= 1'b0;
         rd_bit       <= 1'b0;
         rd_valid     <= 1'b0;
      end else begin
         rd_valid <= slot_ok && state == S_READ;
         if (slot_ok && state == S_READ) begin
            rd_bit <= sif.bit_val;
         end
         if (slot_ok && (state == S_RST_PRE || state == S_RST_POST) && !sif.bit_val) begin
            absent_slave <= 1'b1;
         end else if (state == S_IDLE && start) begin
            absent_slave <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   start_taken_a: assert property (
      state == S_IDLE && start |=> busy && mode_q == $past(mode))
      else $error("start not taken");
   pre_reset_sel_a: assert property (
      state == S_RST_PRE |-> (mode_q & MODE_RST_PRE) != 3'h0)
      else $error("reset before data without mode bit");
   post_reset_sel_a: assert property (
      state == S_RST_POST |-> (mode_q & MODE_RST_POST) != 3'h0)
      else $error("reset after data without mode bit");
   bit_mode_one_a: assert property (
      state == S_DATA && (mode_q & MODE_BIT) != 3'h0 |-> bitn == 3'h0)
      else $error("bit mode moved past bit 0");
   no_presence_abort_a: assert property (
      slot_ok && state == S_RST_PRE && !sif.bit_val |=> state == S_IDLE && absent_slave && done)
      else $error("missing presence not reported");
   reset_then_data_a: assert property (
      state == S_DATA && (mode_q & MODE_RST_PRE) != 3'h0 && idx == 5'h00 && bitn == 3'h0
      && !wait_q |-> $past(state) == S_RST_PRE || $past(state) == S_DATA)
      else $error("data before reset");
   idle_released_a: assert property (
      $fell(busy) |-> !line_oe [*3])
      else $error("line held after completion");
   count_bound_a: assert property (
      state == S_DATA |-> idx < n_items && n_items <= 5'(BUF_DEPTH))
      else $error("item beyond count");
   lsb_first_a: assert property (
      sif.start && state == S_DATA |-> (sif.kind == K_WR1) == mem[idx[3:0]][bitn])
      else $error("wrong bit value sent");
   never_high_a: assert property (
      line_oe |-> line_o == 1'b0)
      else $error("line driven high");

   byte_write_c: cover property (state == S_DATA && mode_q == 3'h0 ##1 done);
   absent_c:     cover property ($rose(absent_slave));
   read_slot_c:  cover property (rd_valid);
   bit_both_c:   cover property (state == S_RST_POST && mode_q == 3'h7);
endmodule : swbw_master

/* tb/swbw_slave_model.sv */
// behavioural slave on the shared line: presence, write decoding, read answers
`timescale 1ns/100ps
module swbw_slave_model
   import swbw_pkg::*;
#(
   parameter int CYC_NS = CLK_NS
) (
   input  wire logic line,
   input  wire logic present,
   input  wire logic rd_en,
   input  wire logic rd_val,
   output logic      pull
);
   logic [1:0] ev[$];
   time        t0;
   int         low;
   initial pull = 1'b0;
   // one process: while it drives the line it cannot mistake its own pulses for slots
   always @(negedge line) begin
      t0 = $time;
      if (rd_en && !rd_val) begin
         pull = 1'b1;
         // let go at the latest legal sample point, so a late sample reads high
         #(RD_MAX_CYC * CYC_NS);
         pull = 1'b0;
      end else begin
         @(posedge line);
         low = int'(($time - t0) / CYC_NS);
         if (low < 100) begin
            ev.push_back(2'h2);
            if (present) begin
               // presence must cover the sample point yet end before the next slot
               #(200 * CYC_NS);
               pull = 1'b1;
               #(1555 * CYC_NS);
               pull = 1'b0;
            end
         end else if (low < 1000) ev.push_back(2'h1);
         else ev.push_back(2'h0);
      end
   end
endmodule : swbw_slave_model

/* tb/swbw_master_tb.sv */
// self-checking bench of the single-wire write master
`timescale 1ns/100ps
module swbw_master_tb;
   import swbw_pkg::*;
   logic       clk, rst_n, start, use_count, rd_start, buf_we;
   logic       present, rd_en, rd_val, pull;
   logic [2:0] mode;
   logic [4:0] count;
   logic [3:0] buf_addr;
   logic [7:0] buf_wdata;
   logic       line_o, line_oe, busy, done, absent_slave, rd_bit, rd_valid;
   wire        line = ~(line_oe | pull);
   int         num_errors, n_compared, cyc;
   logic [1:0] exp[$];

   swbw_master #(.RST_LOW(40), .RST_REC(1760)) dut (
      .clk(clk), .rst_n(rst_n), .start(start), .mode(mode), .use_count(use_count),
      .count(count), .rd_start(rd_start), .buf_we(buf_we), .buf_addr(buf_addr),
      .buf_wdata(buf_wdata), .line_i(line), .line_o(line_o), .line_oe(line_oe),
      .busy(busy), .done(done), .absent_slave(absent_slave), .rd_bit(rd_bit),
      .rd_valid(rd_valid));
   swbw_slave_model slave (.line(line), .present(present), .rd_en(rd_en),
      .rd_val(rd_val), .pull(pull));

   initial clk = 1'b0;
   always #20 clk = ~clk;

   task automatic check(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : check

   task automatic set_slave(input logic p, input logic re, input logic rv);
      present = p;
      rd_en = re;
      rd_val = rv;
   endtask : set_slave

   task automatic results;
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : results

   task automatic wr_buf(input logic [3:0] a, input logic [7:0] d);
      @(negedge clk);
      buf_we = 1'b1;
      buf_addr = a;
      buf_wdata = d;
      @(negedge clk);
      buf_we = 1'b0;
   endtask : wr_buf

   task automatic run_op(input logic [2:0] m, input logic uc, input logic [4:0] c);
      int k;
      @(negedge clk);
      slave.ev.delete();
      mode = m;
      use_count = uc;
      count = c;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 60000) begin
         @(negedge clk);
         k++;
      end
      check(done === 1'b1, "operation never finished");
      check(line_oe === 1'b0 && busy === 1'b0, "line held after end");
   endtask : run_op

   task automatic cmp_ev(input string msg);
      logic ok;
      ok = (slave.ev.size() == exp.size());
      foreach (exp[i]) if (i < slave.ev.size() && slave.ev[i] !== exp[i]) ok = 1'b0;
      check(ok, msg);
   endtask : cmp_ev

   // reset in the middle of a reset slot; no presence, so the model stays quiet
   task automatic t_reset;
      set_slave(1'b0, 1'b0, 1'b0);
      @(negedge clk);
      mode = 3'h1;
      use_count = 1'b1;
      count = 5'h01;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      repeat (20) @(negedge clk);
      check(line_oe === 1'b1 && busy === 1'b1, "reset slot not under way");
      rst_n = 1'b0;
      @(negedge clk);
      check(line_oe === 1'b0 && busy === 1'b0, "outputs kept through reset");
      check(done === 1'b0 && absent_slave === 1'b0, "flags kept through reset");
      rst_n = 1'b1;
      set_slave(1'b1, 1'b0, 1'b0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_modes;
      int         c;
      logic [7:0] v;
      wr_buf(4'h0, 8'h4e);
      for (int m = 0; m < 8; m++) begin
         c = (m == 0 || m >= 4) ? 1 : 0;
         exp.delete();
         if (m[0]) exp.push_back(2'h2);
         if (c != 0 && m[2]) exp.push_back(2'h0);
         if (c != 0 && !m[2]) for (int b = 0; b < 8; b++) begin
            v = 8'h4e >> b;
            exp.push_back({1'b0, v[0]});
         end
         if (m[1]) exp.push_back(2'h2);
         run_op(3'(m), 1'b1, 5'(c));
         cmp_ev("slot sequence wrong for mode");
         check(absent_slave === 1'b0, "absent flag with slave present");
      end
      $display("test modes done");
   endtask : t_modes

   task automatic t_absent;
      set_slave(1'b0, 1'b0, 1'b0);
      exp = '{2'h2};
      run_op(3'h3, 1'b1, 5'h01);
      cmp_ev("data sent after failed reset");
      check(absent_slave === 1'b1, "absent flag not set before data");
      exp = '{2'h0, 2'h2};
      run_op(3'h6, 1'b1, 5'h01);
      cmp_ev("post reset sequence wrong");
      check(absent_slave === 1'b1, "absent flag not set after data");
      set_slave(1'b1, 1'b0, 1'b0);
      exp = '{2'h2};
      run_op(3'h1, 1'b1, 5'h00);
      cmp_ev("slots with zero count");
      check(absent_slave === 1'b0, "absent flag not cleared");
      $display("test absent done");
   endtask : t_absent

   task automatic t_buffer;
      logic [15:0] pat;
      pat = 16'hb2c5;
      for (int i = 0; i < 16; i++) wr_buf(4'(i), {4'(i), 3'h5, pat[i]});
      exp = '{2'h2};
      for (int i = 0; i < 16; i++) exp.push_back({1'b0, pat[i]});
      run_op(3'h5, 1'b0, 5'h03);
      cmp_ev("whole buffer not sent in order");
      exp = '{{1'b0, pat[0]}, {1'b0, pat[1]}, {1'b0, pat[2]}};
      run_op(3'h4, 1'b1, 5'h03);
      cmp_ev("counted run wrong");
      $display("test buffer done");
   endtask : t_buffer

   task automatic t_read;
      int k;
      for (int v = 0; v < 2; v++) begin
         set_slave(1'b1, 1'b1, v[0]);
         @(negedge clk);
         rd_start = 1'b1;
         @(negedge clk);
         rd_start = 1'b0;
         k = 0;
         while (rd_valid !== 1'b1 && k < 2000) begin
            @(negedge clk);
            k++;
         end
         check(rd_bit === v[0] && rd_valid === 1'b1, "read slot value wrong");
         check(k == SLOT_CYC + 3, "read result not at slot end");
         // the result only comes as the slot closes, so the line is already free
         repeat (4) @(negedge clk);
         check(line_oe === 1'b0, "line held after read");
      end
      set_slave(1'b1, 1'b0, 1'b0);
      $display("test read done");
   endtask : t_read

   always @(negedge clk) begin
      if (rst_n && line_oe === 1'b1) check(line_o === 1'b0, "line driven high");
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 95000) begin
         num_errors++;
         $display("mismatch at %0t: run did not finish", $time);
         results();
      end
   end

   initial begin
      {rst_n, start, use_count, rd_start, buf_we} = '0;
      set_slave(1'b1, 1'b0, 1'b0);
      mode = 3'h0;
      count = 5'h00;
      buf_addr = 4'h0;
      buf_wdata = 8'h00;
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_modes();
      t_absent();
      t_buffer();
      t_read();
      results();
   end
endmodule : swbw_master_tb
